// ===== verilog/plc_core.sv
// The Wishbone slave port and the register addresses were decided locally.
`include "plc_params.svh"
`default_nettype none
module plc_core
  import plc_pkg::*;
#(
  parameter int PUR_CYCLES = `PUR_CYC
)
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_pin_clk,
  input  wire logic        i_pin_oe_n,
  input  wire logic [7:0]  i_in,
  input  wire logic [7:0]  i_in_drv,
  input  wire logic [7:0]  i_io,
  input  wire logic [7:0]  i_io_drv,
  output logic [7:0]       o_io,
  output logic [7:0]       o_io_oe
);

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic [33:0] sync1;
  logic [33:0] sync2;
  logic        clk_d;
  logic        clk_s;
  logic        oe_n_s;
  logic [7:0]  in_s;
  logic [7:0]  in_drv_s;
  logic [7:0]  io_s;
  logic [7:0]  io_drv_s;

  // Two flops on every pin before any logic looks at it.
  always_ff @(posedge i_mclk)
  begin
    sync1 <= {i_pin_clk, i_pin_oe_n, i_in, i_in_drv, i_io, i_io_drv};
    sync2 <= sync1;
    clk_d <= clk_s;
  end

  assign {clk_s, oe_n_s, in_s, in_drv_s, io_s, io_drv_s} = sync2;

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic [1:0]  mode;
  logic [15:0] role;
  logic        fuse;
  logic        refused;
  logic [63:0] sig;
  logic [5:0]  pt_addr;
  logic [31:0] pt_mem [64];
  logic [7:0]  q;
  logic [7:0]  keep_in;
  logic [7:0]  keep_io;
  logic [7:0]  io_out;
  logic [7:0]  io_oe;
  logic [$clog2(PUR_CYCLES+1)-1:0] pur_cnt;
  logic        ack;
  logic [31:0] rdat;
  logic [1:0]  next_mode;
  logic [15:0] next_role;
  logic        next_fuse;
  logic        next_refused;
  logic [63:0] next_sig;
  logic [5:0]  next_pt_addr;
  logic [31:0] next_pt_mem [64];
  logic [7:0]  next_q;
  logic [7:0]  next_keep_in;
  logic [7:0]  next_keep_io;
  logic [7:0]  next_io_out;
  logic [7:0]  next_io_oe;
  logic [$clog2(PUR_CYCLES+1)-1:0] next_pur_cnt;
  logic        next_ack;
  logic [31:0] next_rdat;

  // Byte-lane merge of a bus write into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // ****************************************************************
  // Logic array and macrocells.
  // ****************************************************************
  logic        pur_done;
  logic        clk_edge;
  logic        reg_mode;
  logic [7:0]  fb;
  logic [15:0] vec;
  logic [7:0]  cell_d;
  logic [7:0]  cell_oe;
  logic [255:0] terms [8];

  assign pur_done = (pur_cnt == PUR_CYCLES[$bits(pur_cnt)-1:0]);
  // Clock pin edges are ignored until the reset interval has run.
  assign clk_edge = clk_s & ~clk_d & pur_done;
  assign reg_mode = (mode_e'(mode) == MODE_REGISTERED);

  // Feedback selection per mode, and term slices per cell.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      fb[i] = (reg_mode && role_e'(role[2*i +: 2]) == ROLE_REG) ?
              q[i] : keep_io[i];
      for (int k = 0; k < 8; k++)
      begin
        terms[i][32*k +: 32] = pt_mem[8*i+k];
      end
    end
    if (!reg_mode)
    begin
      fb[0] = oe_n_s;
      fb[7] = clk_s;
    end
    if (mode_e'(mode) == MODE_SIMPLE)
    begin
      fb[3] = 1'b0;
      fb[4] = 1'b0;
    end
    vec = {fb, keep_in};
  end

  // Eight macrocells, each with its own role.
  for (genvar g = 0; g < 8; g++)
  begin : g_cell
    plc_cell #(.IDX(g)) u_cell
    (
      .i_vec    (vec),
      .i_terms  (terms[g]),
      .i_mode   (mode),
      .i_role   (role[2*g +: 2]),
      .i_oe_pin (~oe_n_s),
      .o_d      (cell_d[g]),
      .o_oe     (cell_oe[g])
    );
  end

  // ****************************************************************
  // Bus slave, preload, registers and pins: next values.
  // ****************************************************************
  always_comb
  begin
    logic        req;
    logic [31:0] w;
    req          = i_wb_cyc & i_wb_stb & ~ack;
    w            = i_wb_dat;
    next_mode    = mode;
    next_role    = role;
    next_fuse    = fuse;
    next_sig     = sig;
    next_pt_addr = pt_addr;
    next_pt_mem  = pt_mem;
    next_q       = q;
    next_ack     = req;
    next_rdat    = rdat;
    next_pur_cnt = pur_done ? pur_cnt : pur_cnt + 1'b1;
    next_refused = refused;
    // Register clock edge loads registered cells.
    if (clk_edge && reg_mode)
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (role_e'(role[2*i +: 2]) == ROLE_REG)
        begin
          next_q[i] = cell_d[i];
        end
      end
    end
    if (req && i_wb_we)
    begin
      case (i_wb_adr)
        `OFS_CTRL:
        begin
          w = merge({29'h0, fuse, mode}, i_wb_dat, i_wb_sel);
          next_mode = w[1:0];
          next_fuse = fuse | w[`CTRL_FUSE_BIT];
        end
        `OFS_ROLE:
        begin
          w = merge({16'h0, role}, i_wb_dat, i_wb_sel);
          next_role = w[15:0];
        end
        `OFS_PRELOAD:
        begin
          w = merge(32'h0, i_wb_dat, i_wb_sel);
          if (!fuse)
          begin
            next_q = (q & ~w[15:8]) | (w[7:0] & w[15:8]);
          end
        end
        `OFS_SIG_LO:
        begin
          next_sig[31:0] = merge(sig[31:0], i_wb_dat, i_wb_sel);
        end
        `OFS_SIG_HI:
        begin
          next_sig[63:32] = merge(sig[63:32], i_wb_dat, i_wb_sel);
        end
        `OFS_PT_ADDR:
        begin
          w = merge({26'h0, pt_addr}, i_wb_dat, i_wb_sel);
          next_pt_addr = w[5:0];
        end
        `OFS_PT_DATA:
        begin
          next_pt_mem[pt_addr] = merge(pt_mem[pt_addr], i_wb_dat,
                                       i_wb_sel);
        end
        default:
        begin
          next_mode = mode;
        end
      endcase
    end
    if (req && !i_wb_we)
    begin
      case (i_wb_adr)
        `OFS_CTRL:    next_rdat = {29'h0, fuse, mode};
        `OFS_ROLE:    next_rdat = {16'h0, role};
        `OFS_STATUS:  next_rdat = {13'h0, pur_done, refused, fuse,
                                   keep_io, q};
        `OFS_SIG_LO:  next_rdat = sig[31:0];
        `OFS_SIG_HI:  next_rdat = sig[63:32];
        `OFS_PT_ADDR: next_rdat = {26'h0, pt_addr};
        `OFS_PT_DATA: next_rdat = fuse ? 32'h0 : pt_mem[pt_addr];
        default:      next_rdat = 32'h0;
      endcase
    end
    // Refused flag: a new refusal wins over a clear in the same cycle.
    if (req && i_wb_we && i_wb_adr == `OFS_STATUS && i_wb_sel[2] &&
        i_wb_dat[`STAT_REFUSE_BIT])
    begin
      next_refused = 1'b0;
    end
    if (req && fuse && ((i_wb_we && i_wb_adr == `OFS_PRELOAD) ||
        (!i_wb_we && i_wb_adr == `OFS_PT_DATA)))
    begin
      next_refused = 1'b1;
    end
    // Keepers hold the last driven level of each pin.
    for (int i = 0; i < 8; i++)
    begin
      next_keep_in[i] = in_drv_s[i] ? in_s[i] : keep_in[i];
      next_keep_io[i] = io_oe[i] ? io_out[i] :
                        (io_drv_s[i] ? io_s[i] : keep_io[i]);
      next_io_out[i]  = (reg_mode && role_e'(role[2*i +: 2]) == ROLE_REG)
                        ? ~q[i] : ~cell_d[i];
    end
    next_io_oe = cell_oe;
  end

  // ****************************************************************
  // State registers.
  // ****************************************************************
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      mode    <= `RST_MODE;
      role    <= `RST_ROLE;
      fuse    <= 1'b0;
      refused <= 1'b0;
      sig     <= {`RST_SIG, `RST_SIG};
      pt_addr <= 6'h00;
      q       <= 8'h00;
      keep_in <= 8'h00;
      keep_io <= 8'h00;
      io_out  <= 8'hFF;
      io_oe   <= 8'h00;
      pur_cnt <= '0;
      ack     <= 1'b0;
      rdat    <= 32'h0;
    end
    else
    begin
      mode    <= next_mode;
      role    <= next_role;
      fuse    <= next_fuse;
      refused <= next_refused;
      sig     <= next_sig;
      pt_addr <= next_pt_addr;
      q       <= next_q;
      keep_in <= next_keep_in;
      keep_io <= next_keep_io;
      io_out  <= next_io_out;
      io_oe   <= next_io_oe;
      pur_cnt <= next_pur_cnt;
      ack     <= next_ack;
      rdat    <= next_rdat;
    end
  end

  // Pattern store; not cleared by reset, as it models non-volatile cells.
  always_ff @(posedge i_mclk)
  begin
    pt_mem <= next_pt_mem;
  end

  // Port drives.
  assign o_wb_ack = ack;
  assign o_wb_dat = rdat;
  assign o_io     = io_out;
  assign o_io_oe  = io_oe;
endmodule : plc_core
`default_nettype wire

// ===== verilog/plc_params.svh
// Functional notes
// - Power-up reset clears every macrocell register low.
// - Registered pins read high after reset.
// - Preload forces any register high or low.
// - Security fuse blocks verify and preload.
// - Eight-byte signature stays readable always.
// - Undriven pins keep their last level.
// - Four roles per macrocell.
// - Three architecture modes; mode value 2 is also accepted and turns every cell off.
// - Registered mode: fixed clock and enable pins.
// - Registered mode combinational: one enable, seven terms.
// - Complex mode: seven terms, term enable, outer outputs.
// - Simple mode: eight terms, centre cells always on.
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses).
// ****************************************************************
`define OFS_CTRL    8'h00
`define OFS_ROLE    8'h04
`define OFS_STATUS  8'h08
`define OFS_PRELOAD 8'h0C
`define OFS_SIG_LO  8'h10
`define OFS_SIG_HI  8'h14
`define OFS_PT_ADDR 8'h18
`define OFS_PT_DATA 8'h1C

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define CTRL_FUSE_BIT   2
`define STAT_FUSE_BIT   16
`define STAT_REFUSE_BIT 17
`define STAT_PUR_BIT    18
`define RST_MODE        2'h3
`define RST_ROLE        16'h0000
`define RST_SIG         32'h00000000

// ****************************************************************
// Timing: longest reset interval, in ns and in clock cycles.
// ****************************************************************
`define CLK_PERIOD_NS 8
`define PUR_MAX_NS    1000
`define PUR_CYC       (`PUR_MAX_NS / `CLK_PERIOD_NS)

`endif

// ===== verilog/plc_pkg.sv
`default_nettype none
package plc_pkg;
  // Architecture modes, Gray coded.
  typedef enum logic [1:0]
  {
    MODE_SIMPLE     = 2'h0,
    MODE_COMPLEX    = 2'h1,
    MODE_REGISTERED = 2'h3
  } mode_e;

  // Macrocell roles.
  typedef enum logic [1:0]
  {
    ROLE_REG      = 2'h0,
    ROLE_COMB_IO  = 2'h1,
    ROLE_COMB_OUT = 2'h3,
    ROLE_INPUT    = 2'h2
  } role_e;
endpackage : plc_pkg
`default_nettype wire

// ===== verilog/plc_cell.sv
`default_nettype none
module plc_cell
  import plc_pkg::*;
#(
  parameter int IDX = 0
)
(
  input  wire logic [15:0]  i_vec,
  input  wire logic [255:0] i_terms,
  input  wire logic [1:0]   i_mode,
  input  wire logic [1:0]   i_role,
  input  wire logic         i_oe_pin,
  output logic              o_d,
  output logic              o_oe
);

  // One product term: bit 2k selects input k, bit 2k+1 its complement.
  function automatic logic pterm(input logic [31:0] mask,
                                 input logic [15:0] vec);
    logic [31:0] lits;
    lits = '0;
    for (int k = 0; k < 16; k++)
    begin
      lits[2*k]   = vec[k];
      lits[2*k+1] = ~vec[k];
    end
    return (|mask) & (&(lits | ~mask));
  endfunction : pterm

  logic [7:0] t;
  logic       sum7;
  logic       sum8;

  // Sum and enable selection by mode and role.
  always_comb
  begin
    for (int k = 0; k < 8; k++)
    begin
      t[k] = pterm(i_terms[32*k +: 32], i_vec);
    end
    sum7 = |t[7:1];
    sum8 = |t;
    o_d  = 1'b0;
    o_oe = 1'b0;
    case (mode_e'(i_mode))
      MODE_REGISTERED:
      begin
        if (role_e'(i_role) == ROLE_REG)
        begin
          o_d  = sum8;
          o_oe = i_oe_pin;
        end
        else if (role_e'(i_role) != ROLE_INPUT)
        begin
          o_d  = sum7;
          o_oe = t[0];
        end
      end
      MODE_COMPLEX:
      begin
        o_d = sum7;
        if (IDX == 0 || IDX == 7 || role_e'(i_role) != ROLE_INPUT)
        begin
          o_oe = t[0];
        end
      end
      MODE_SIMPLE:
      begin
        o_d = sum8;
        if (IDX == 3 || IDX == 4 || role_e'(i_role) != ROLE_INPUT)
        begin
          o_oe = 1'b1;
        end
      end
      default:
      begin
        o_d  = 1'b0;
        o_oe = 1'b0;
      end
    endcase
  end
endmodule : plc_cell
`default_nettype wire

// ===== verif/plc_props.sv
`include "plc_params.svh"
`default_nettype none
module plc_props
  import plc_pkg::*;
#(
  parameter int PUR_CYCLES = `PUR_CYC
)
(
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_pin_oe_n,
  input wire logic [7:0]  o_io,
  input wire logic [7:0]  o_io_oe
);
  // ****************************************************************
  // Bus, reset and protection checks.
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  logic fuse_seen;
  logic cfg_default;
  logic wr_take;
  logic rd_ack;

  // Write taken this edge, and a read answer in this cycle.
  assign wr_take = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
  assign rd_ack  = o_wb_ack && !i_wb_we;

  // Tracks the protection bit and whether the power-up setup still stands.
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      fuse_seen   <= 1'b0;
      cfg_default <= 1'b1;
    end
    else if (wr_take)
    begin
      if (i_wb_adr == `OFS_CTRL && i_wb_dat[`CTRL_FUSE_BIT])
        fuse_seen <= 1'b1;
      if (i_wb_adr == `OFS_CTRL || i_wb_adr == `OFS_ROLE)
        cfg_default <= 1'b0;
    end
  end

  // A request seen at an edge while no answer is pending.
  sequence req_taken;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence

  // The enable pin held still long enough to cross the synchroniser.
  sequence oe_pin_steady;
    $stable(i_pin_oe_n) [*5];
  endsequence

  a_ack_follows_req: assert property (req_taken |=> o_wb_ack)
    else $error("ack missing one cycle after request");
  a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_ack_has_cause: assert property (
    o_wb_ack |-> $past(i_wb_stb) && $past(i_wb_cyc))
    else $error("ack without a request");
  a_reset_state: assert property (
    $fell(i_rst) |-> o_io == 8'hFF && o_io_oe == 8'h00 && !o_wb_ack)
    else $error("pins not at power-up state");
  a_oe_follows_pin: assert property (
    (oe_pin_steady ##0 cfg_default) |-> o_io_oe == {8{!i_pin_oe_n}})
    else $error("registered outputs ignore the enable pin");
  a_verify_blocked: assert property (
    fuse_seen && rd_ack && i_wb_adr == `OFS_PT_DATA |-> o_wb_dat == 32'h0)
    else $error("pattern readable while protected");
  a_status_fuse: assert property (
    rd_ack && i_wb_adr == `OFS_STATUS
    |-> o_wb_dat[`STAT_FUSE_BIT] == fuse_seen)
    else $error("protection flag wrong in status");
  a_unmapped_zero: assert property (
    rd_ack && i_wb_adr > `OFS_PT_DATA |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
endmodule : plc_props

bind plc_core plc_props #(.PUR_CYCLES(PUR_CYCLES)) props_u (.i_mclk, .i_rst,
  .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .o_wb_dat,
  .o_wb_ack, .i_pin_oe_n, .o_io, .o_io_oe);
`default_nettype wire

// ===== verif/board_model.sv
`default_nettype none
module board_model
(
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_ext_en,
  input  wire logic [7:0] i_dev_io,
  input  wire logic [7:0] i_dev_oe,
  input  wire logic       i_clk_lvl,
  output logic [7:0]      o_wire,
  output logic            o_pin_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Board wiring of the io pins.
  // ****************************************************************
  logic [7:0] last = 8'h00;

  // The bench holds the clock pin low through reset and its interval,
  // and raises it only once the pattern has long been settled.
  assign o_pin_clk = i_clk_lvl;

  // A wire that nobody drives shows a changing level, so only the
  // device's keeper can make it look held.
  always_comb
  begin
    for (int k = 0; k < 8; k++)
      o_wire[k] = i_ext_en[k] ? i_ext_val[k]
                : (i_dev_oe[k] ? i_dev_io[k] : ~last[k]);
  end

  // Remembers the level each wire carried at the last edge.
  always_ff @(posedge i_mclk)
  begin
    last <= o_wire;
  end
endmodule : board_model
`default_nettype wire

// ===== verif/tb.sv
`include "plc_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Bench for the macrocell configuration block.
  // ****************************************************************
  localparam int PUR = 4;
  logic        i_mclk;
  logic        i_rst;
  logic        i_wb_cyc;
  logic        i_wb_stb;
  logic        i_wb_we;
  logic [7:0]  i_wb_adr;
  logic [31:0] i_wb_dat;
  logic [31:0] o_wb_dat;
  logic        o_wb_ack;
  logic        i_pin_clk;
  logic        i_pin_oe_n;
  logic [7:0]  ext_val;
  logic [7:0]  ext_en;
  logic [7:0]  i_io;
  logic [7:0]  o_io;
  logic [7:0]  o_io_oe;
  logic [31:0] rd;
  logic        clk_lvl;
  logic [23:0] pin_view;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_cycles = 0;

  // Free-running system clock.
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  plc_core #(.PUR_CYCLES(PUR)) dut_u (.i_mclk, .i_rst, .i_wb_cyc,
    .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel(4'hF), .i_wb_dat,
    .o_wb_dat, .o_wb_ack, .i_pin_clk, .i_pin_oe_n, .i_in(8'h00),
    .i_in_drv(8'hFF), .i_io, .i_io_drv(ext_en), .o_io, .o_io_oe);
  board_model board_u (.i_mclk, .i_ext_val(ext_val), .i_ext_en(ext_en),
    .i_dev_io(o_io), .i_dev_oe(o_io_oe), .i_clk_lvl(clk_lvl),
    .o_wire(i_io), .o_pin_clk(i_pin_clk));

  // Pin levels captured mid-cycle, once they have settled after an edge.
  always @(negedge i_mclk)
  begin
    pin_view <= {i_io, o_io_oe, o_io};
  end

  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic bus cycle, held until the answer is sampled.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do
    begin
      @(posedge i_mclk);
    end
    while (o_wb_ack !== 1'b1);
    r = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
    @(posedge i_mclk);
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    wb(1'b0, a, 32'h0, rd);
    chk(rd & m, e);
  endtask : rdc

  task automatic t_reset;
    chk({24'h0, pin_view[7:0]}, 32'hFF);
    rdc(`OFS_STATUS, 32'h400FF, 32'h00);
    rdc(`OFS_CTRL, 32'h3, {30'h0, `RST_MODE});
    rdc(`OFS_ROLE, 32'hFFFF, {16'h0, `RST_ROLE});
    repeat (PUR + 2) @(posedge i_mclk);
    rdc(`OFS_STATUS, 32'h40000, 32'h40000);
  endtask : t_reset

  task automatic t_preload;
    wb(1'b1, `OFS_PRELOAD, 32'h0000FFA5, rd);
    rdc(`OFS_STATUS, 32'hFF, 32'hA5);
    repeat (3) @(posedge i_mclk);
    chk({24'h0, pin_view[7:0]}, 32'h5A);
    wb(1'b1, `OFS_PRELOAD, 32'h00000F00, rd);
    rdc(`OFS_STATUS, 32'hFF, 32'hA0);
  endtask : t_preload

  task automatic t_pins;
    i_pin_oe_n <= 1'b1;
    repeat (5) @(posedge i_mclk);
    chk({24'h0, pin_view[15:8]}, 32'h00);
    ext_val <= 8'h5A;
    ext_en  <= 8'hFF;
    repeat (5) @(posedge i_mclk);
    ext_en <= 8'h00;
    repeat (5) @(posedge i_mclk);
    rdc(`OFS_STATUS, 32'hFF00, 32'h5A00);
    i_pin_oe_n <= 1'b0;
    repeat (5) @(posedge i_mclk);
    chk({24'h0, pin_view[15:8]}, 32'hFF);
    chk({24'h0, pin_view[23:16]}, 32'h5F);
    rdc(`OFS_STATUS, 32'hFF00, 32'h5F00);
  endtask : t_pins

  // Roles all input in each mode, all registered for mode value 2; only the always-on cells may drive, and the outer cells go unchecked in complex mode.
  task automatic t_modes;
    logic [1:0]  md [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
    logic [15:0] rl [4] = '{16'hAAAA, 16'hAAAA, 16'h0000, 16'hAAAA};
    logic [7:0]  mk [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h7E};
    logic [7:0]  ex [4] = '{8'h00, 8'h18, 8'h00, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, `OFS_ROLE, {16'h0, rl[i]}, rd);
      wb(1'b1, `OFS_CTRL, {30'h0, md[i]}, rd);
      repeat (5) @(posedge i_mclk);
      rd = {24'h0, pin_view[15:8] & mk[i]};
      chk(rd, {24'h0, ex[i]});
      rdc(`OFS_CTRL, 32'h3, {30'h0, md[i]});
    end
    wb(1'b1, `OFS_ROLE, 32'h0, rd);
    wb(1'b1, `OFS_CTRL, 32'h3, rd);
  endtask : t_modes

  task automatic t_fuse;
    wb(1'b1, `OFS_SIG_LO, 32'h12345678, rd);
    wb(1'b1, `OFS_SIG_HI, 32'h9ABCDEF0, rd);
    wb(1'b1, `OFS_PT_ADDR, 32'h5, rd);
    wb(1'b1, `OFS_PT_DATA, 32'h1, rd);
    rdc(`OFS_PT_DATA, 32'hFFFFFFFF, 32'h1);
    wb(1'b1, `OFS_CTRL, 32'h7, rd);
    wb(1'b1, `OFS_PRELOAD, 32'h0000FF00, rd);
    rdc(`OFS_STATUS, 32'h300FF, 32'h30001);
    rdc(`OFS_PT_DATA, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, `OFS_STATUS, 32'h00020000, rd);
    rdc(`OFS_STATUS, 32'h30000, 32'h10000);
    wb(1'b1, `OFS_CTRL, 32'h3, rd);
    rdc(`OFS_CTRL, 32'h4, 32'h4);
    rdc(`OFS_SIG_LO, 32'hFFFFFFFF, 32'h12345678);
    rdc(`OFS_SIG_HI, 32'hFFFFFFFF, 32'h9ABCDEF0);
    rdc(8'h40, 32'hFFFFFFFF, 32'h0);
  endtask : t_fuse

  // Clears the pattern store, lets one term drive cell 0, then clocks
  // the registers once through the clock pin.
  task automatic t_clock;
    for (int a = 0; a < 64; a++)
    begin
      wb(1'b1, `OFS_PT_ADDR, 32'(a), rd);
      wb(1'b1, `OFS_PT_DATA, (a == 0) ? 32'h2 : 32'h0, rd);
    end
    rdc(`OFS_STATUS, 32'hFF, 32'hA0);
    clk_lvl <= 1'b1;
    repeat (5) @(posedge i_mclk);
    clk_lvl <= 1'b0;
    repeat (5) @(posedge i_mclk);
    rdc(`OFS_STATUS, 32'hFF, 32'h01);
    chk({24'h0, pin_view[7:0]}, 32'hFE);
  endtask : t_clock

  // A second reset in mid-run brings back the power-up state.
  task automatic t_rerun;
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    chk({16'h0, pin_view[15:0]}, 32'h00FF);
    rdc(`OFS_STATUS, 32'h700FF, 32'h0);
    rdc(`OFS_CTRL, 32'h7, 32'h3);
  endtask : t_rerun

  // Main sequence: power-up reset, then each scenario in turn.
  initial
  begin
    i_rst      = 1'b1;
    i_wb_cyc   = 1'b0;
    i_wb_stb   = 1'b0;
    i_wb_we    = 1'b0;
    i_wb_adr   = 8'h00;
    i_wb_dat   = 32'h0;
    i_pin_oe_n = 1'b0;
    ext_val    = 8'h00;
    ext_en     = 8'h00;
    clk_lvl    = 1'b0;
    repeat (12) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    t_reset();
    t_preload();
    t_pins();
    t_modes();
    t_clock();
    t_fuse();
    t_rerun();
    give_verdict();
  end

  // Cuts a hang short well beyond the expected run length.
  always @(posedge i_mclk)
  begin
    n_cycles <= n_cycles + 1;
    if (n_cycles == 3000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
endmodule : tb
`default_nettype wire
